// ===== hw/rdt_timer.sv
// Purpose: One 16-bit reloadable down timer channel
// Assumes: Oscillator and event inputs are asynchronous and slow
// Notes: Each source is edge-sampled on core_clk, so sources must run below 25 MHz
`timescale 1ns/100ps
module rdt_timer
   import rdt_pkg::*;
#(
   parameter bit HAS_EVENT_COUNTER = 1'b1
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [7:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [15:0] regRdData,
   input wire logic internalOsc,
   input wire logic lowFreqOsc,
   input wire logic highFreqOsc,
   input wire logic extOscClock,
   input wire logic extEventIn,
   input wire logic sleepMode,
   input wire logic sleepClockStopBit,
   input wire logic debugMode,
   output logic underflowPulse,
   output logic periphClock,
   output logic irqOut
);
   // ************************************************************
   // Source synchronisers and edge detect
   // ************************************************************
   logic [4:0] oscRaw;
   logic [4:0] oscMeta;
   logic [4:0] oscSync;
   logic [4:0] oscPrev;
   logic [4:0] oscEdge;
   logic [4:0] next_oscMeta, next_oscSync, next_oscPrev;

   // External slot picks event pin or external oscillator by build option
   assign oscRaw = {HAS_EVENT_COUNTER ? extEventIn : extOscClock, // R4 R5
                    highFreqOsc, lowFreqOsc, internalOsc, 1'b0};

   // Only the second and third stages feed logic, so a metastable first stage never spreads
   always_comb begin
      next_oscMeta = oscRaw;
      next_oscSync = oscMeta;
      next_oscPrev = oscSync;
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         oscMeta <= '0;
         oscSync <= '0;
         oscPrev <= '0;
      end else begin
         oscMeta <= next_oscMeta;
         oscSync <= next_oscSync;
         oscPrev <= next_oscPrev;
      end
   end
   assign oscEdge = oscSync & ~oscPrev;

   function automatic logic divDone(input logic [RDT_PRESCALE_W-1:0] pre,
                                    input logic [3:0] sel);
      logic [RDT_PRESCALE_W-1:0] mask;
      mask = RDT_PRESCALE_W'((16'h1 << sel) - 16'h1);
      divDone = ((pre | ~mask) == '1);
   endfunction

   // ************************************************************
   // Control state
   // ************************************************************
   rdt_ctrl_s ctrl, next_ctrl;
   logic [15:0] reload, next_reload;
   logic [15:0] count, next_count;
   logic [RDT_PRESCALE_W-1:0] prescale, next_prescale;
   logic run, next_run;
   logic presetBusy, next_presetBusy;
   logic flag, next_flag;
   logic [15:0] next_regRdData;
   logic next_underflowPulse, next_periphClock, next_irqOut;
   logic srcEdge, gateOpen, countTick, ufEvent, wrCtl, enNow;

   always_comb begin
      case (ctrl.clockSourceSel) // R14
         RDT_SRC_INT: srcEdge = oscEdge[1];
         RDT_SRC_LOW: srcEdge = oscEdge[2];
         RDT_SRC_HIGH: srcEdge = oscEdge[3];
         default: srcEdge = oscEdge[4];
      endcase
   end

   // Operating clock gate: enable, sleep stop and debug hold
   assign gateOpen = ctrl.moduleEnable // R7
                     && !(sleepMode && sleepClockStopBit) // R1
                     && !(debugMode && !ctrl.debugRun); // R2 R3
   // External source is never divided
   assign countTick = srcEdge && gateOpen && (ctrl.clockSourceSel == RDT_SRC_EXT
                      || divDone(prescale, ctrl.clockDividerSel)); // R15 R4
   assign ufEvent = countTick && run && !presetBusy && (count == 16'h0); // R21 R8
   assign wrCtl = regWrite && (regAddr == RDT_CTL_OFS);
   // Enable written in the same cycle counts as set beforehand
   assign enNow = ctrl.moduleEnable || regWrData[RDT_MODULE_ENABLE_BIT]; // R7

   always_comb begin
      next_ctrl = ctrl;
      next_reload = reload;
      next_count = count;
      next_prescale = prescale;
      next_run = run;
      next_presetBusy = 1'b0; // R18
      next_flag = flag;
      next_regRdData = 16'h0;
      next_underflowPulse = ufEvent; // R8
      next_periphClock = periphClock;
      // Prescaler free-runs across divider changes, so the first tick may come early
      if (srcEdge && gateOpen) begin
         next_prescale = prescale + 1'b1;
      end
      if (presetBusy) begin
         next_count = reload; // R17
      end else if (countTick && run) begin
         next_count = (count == 16'h0) ? reload : count - 16'h1; // R9 R19
      end
      if (ufEvent) begin
         if (ctrl.repeatOneshotSel) begin
            next_run = 1'b0; // R11
         end else begin
            next_periphClock = ~periphClock; // R8 R10
         end
      end
      if (regWrite) begin
         if (regAddr == RDT_CLK_OFS) begin
            next_ctrl.debugRun = regWrData[RDT_DEBUG_RUN_BIT];
            next_ctrl.clockDividerSel = regWrData[RDT_DIV_LSB +: 4];
            next_ctrl.clockSourceSel = regWrData[1:0];
         end else if (regAddr == RDT_MOD_OFS) begin
            next_ctrl.repeatOneshotSel = regWrData[0];
         end else if (wrCtl) begin
            next_ctrl.moduleEnable = regWrData[RDT_MODULE_ENABLE_BIT];
            if (!regWrData[RDT_RUN_BIT]) begin
               next_run = 1'b0; // R16
            end else if (enNow) begin
               next_run = 1'b1; // R16 R7
            end
            if (regWrData[RDT_PRESET_BIT] && enNow) begin
               next_presetBusy = 1'b1; // R17 R7
            end
         end else if (regAddr == RDT_RLD_OFS) begin
            next_reload = regWrData; // R19
         end else if (regAddr == RDT_IEN_OFS) begin
            next_ctrl.underflowIrqEn = regWrData[0];
         end
      end
      // Set wins over a same-cycle write-one clear
      if (ufEvent) begin
         next_flag = 1'b1; // R13
      end else if (regWrite && regAddr == RDT_FLG_OFS && regWrData[0]) begin
         next_flag = 1'b0; // R13
      end
      next_irqOut = next_flag && next_ctrl.underflowIrqEn; // R13
      if (regRead) begin
         if (regAddr == RDT_CLK_OFS) begin
            next_regRdData = {7'h0, ctrl.debugRun, ctrl.clockDividerSel, 2'h0,
                              ctrl.clockSourceSel};
         end else if (regAddr == RDT_MOD_OFS) begin
            next_regRdData = {15'h0, ctrl.repeatOneshotSel};
         end else if (regAddr == RDT_CTL_OFS) begin
            next_regRdData = {7'h0, run, 6'h0, presetBusy, ctrl.moduleEnable}; // R16 R17
         end else if (regAddr == RDT_RLD_OFS) begin
            next_regRdData = reload;
         end else if (regAddr == RDT_CNT_OFS) begin
            // Same clock here, so a single read is already coherent
            next_regRdData = count; // R12
         end else if (regAddr == RDT_FLG_OFS) begin
            next_regRdData = {15'h0, flag};
         end else if (regAddr == RDT_IEN_OFS) begin
            next_regRdData = {15'h0, ctrl.underflowIrqEn};
         end else begin
            next_regRdData = 16'h0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         ctrl <= '0;
         reload <= RDT_RELOAD_RST;
         count <= RDT_RELOAD_RST;
         prescale <= '0;
         run <= 1'b0;
         presetBusy <= 1'b0;
         flag <= 1'b0;
         regRdData <= 16'h0;
         underflowPulse <= 1'b0;
         periphClock <= 1'b0;
         irqOut <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         reload <= next_reload;
         count <= next_count;
         prescale <= next_prescale;
         run <= next_run;
         presetBusy <= next_presetBusy;
         flag <= next_flag;
         regRdData <= next_regRdData;
         underflowPulse <= next_underflowPulse;
         periphClock <= next_periphClock;
         irqOut <= next_irqOut;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   preset_clears_a: assert property (presetBusy && !(wrCtl && regWrData[RDT_PRESET_BIT]) // R18
      |=> !presetBusy)
      else $error("preset bit did not clear");
   preset_loads_a: assert property (presetBusy |=> count == $past(reload)) // R17
      else $error("preset did not load reload value");
   underflow_reload_a: assert property (ufEvent // R21
      |=> count == $past(reload) && underflowPulse)
      else $error("underflow did not reload and pulse");
   count_step_a: assert property (countTick && run && !presetBusy && count != 16'h0 // R9
      |=> count == $past(count) - 16'h1)
      else $error("counter did not decrement");
   oneshot_stop_a: assert property (ufEvent && ctrl.repeatOneshotSel && !wrCtl // R11
      |=> !run)
      else $error("one-shot did not stop");
   repeat_runs_a: assert property (ufEvent && !ctrl.repeatOneshotSel && !wrCtl // R10
      |=> run && periphClock != $past(periphClock))
      else $error("repeat mode stopped");
   flag_set_a: assert property (ufEvent |=> flag && irqOut == ctrl.underflowIrqEn) // R13
      else $error("flag or interrupt wrong");
   gate_hold_a: assert property (!gateOpen && !presetBusy |=> count == $past(count)) // R1
      else $error("counter moved while clock withheld");
   enable_start_a: assert property (wrCtl && !ctrl.moduleEnable // R7
      && !regWrData[RDT_MODULE_ENABLE_BIT] && !run |=> !run && !presetBusy)
      else $error("start without module enable");

   // ************************************************************
   // Register and gate checks
   // ************************************************************
   prescale_hold_a: assert property (!gateOpen |=> prescale == $past(prescale)) // R2
      else $error("prescaler moved while clock withheld");
   sleep_gate_a: assert property (sleepMode && sleepClockStopBit |-> !countTick) // R1
      else $error("tick during sleep clock stop");
   debug_gate_a: assert property (debugMode && !ctrl.debugRun |-> !countTick) // R2
      else $error("tick during debug hold");
   debug_run_a: assert property (debugMode && ctrl.debugRun && ctrl.moduleEnable // R3
      && !(sleepMode && sleepClockStopBit) |-> gateOpen)
      else $error("debug-run withheld the clock");
   ext_undivided_a: assert property (srcEdge && gateOpen // R15
      && ctrl.clockSourceSel == RDT_SRC_EXT |-> countTick)
      else $error("external source was divided");
   run_stop_a: assert property (wrCtl && !regWrData[RDT_RUN_BIT] |=> !run) // R16
      else $error("run bit did not stop");
   run_start_a: assert property (wrCtl && regWrData[RDT_RUN_BIT] // R16
      && regWrData[RDT_MODULE_ENABLE_BIT] |=> run)
      else $error("run bit did not start");
   idle_hold_a: assert property (!run && !presetBusy |=> count == $past(count)) // R16
      else $error("idle counter moved");
   run_read_a: assert property (regRead && regAddr == RDT_CTL_OFS // R16
      |=> regRdData[RDT_RUN_BIT] == $past(run))
      else $error("run bit read wrong");
   busy_read_a: assert property (regRead && regAddr == RDT_CTL_OFS // R17
      |=> regRdData[RDT_PRESET_BIT] == $past(presetBusy))
      else $error("preset bit read wrong");
   count_read_a: assert property (regRead && regAddr == RDT_CNT_OFS // R12
      |=> regRdData == $past(count))
      else $error("counter read wrong");
   reload_write_a: assert property (regWrite && regAddr == RDT_RLD_OFS // R19
      |=> reload == $past(regWrData))
      else $error("reload write lost");
   clk_write_a: assert property (regWrite && regAddr == RDT_CLK_OFS // R14
      |=> ctrl.clockSourceSel == $past(regWrData[1:0])
      && ctrl.clockDividerSel == $past(regWrData[RDT_DIV_LSB +: 4]))
      else $error("clock control write lost");
   debug_run_write_a: assert property (regWrite && regAddr == RDT_CLK_OFS // R3
      |=> ctrl.debugRun == $past(regWrData[RDT_DEBUG_RUN_BIT]))
      else $error("debug-run write lost");
   mode_write_a: assert property (regWrite && regAddr == RDT_MOD_OFS // R10
      |=> ctrl.repeatOneshotSel == $past(regWrData[0]))
      else $error("mode write lost");
   flag_clear_a: assert property (regWrite && regAddr == RDT_FLG_OFS // R13
      && regWrData[0] && !ufEvent |=> !flag)
      else $error("flag did not clear");
   flag_keep_a: assert property (flag && !(regWrite && regAddr == RDT_FLG_OFS // R13
      && regWrData[0]) |=> flag)
      else $error("flag lost without clear");
   irq_level_a: assert property (irqOut == (flag && ctrl.underflowIrqEn)) // R13
      else $error("interrupt request wrong");
   periph_oneshot_a: assert property (ctrl.repeatOneshotSel // R8
      |=> periphClock == $past(periphClock))
      else $error("clock output moved in one-shot");

   sleep_hold_c: cover property (sleepMode && sleepClockStopBit && run);
   oneshot_c: cover property (ufEvent && ctrl.repeatOneshotSel);
   repeat_c: cover property (ufEvent && !ctrl.repeatOneshotSel ##[1:200] ufEvent);
   debug_hold_c: cover property (debugMode && run && !ctrl.debugRun);
   flag_race_c: cover property (ufEvent && regWrite && regAddr == RDT_FLG_OFS);
endmodule

// ===== hw/rdt_pkg.sv
// Purpose: Constants and types for the reloadable down timer channel
// Assumes: 16-bit register data on a plain strobe port
// Notes: Register offsets are byte addresses
// Function
// [R1] Sleep clock-stop halts counting, keeps state
// [R2] Debug without debug-run withholds counting clock
// [R3] Debug with debug-run keeps counting
// [R4] Source 3 counts event rising edges
// [R5] Without event counting source 3 is external oscillator
// [R6] Software follows documented start order
// [R7] Module enable gates clock, start, preset
// [R8] Underflow pulse feeds interrupt and peripheral clock; periphClock toggles in repeat mode only
// [R9] Underflow period is reload plus one
// [R10] Repeat mode runs and reloads periodically
// [R11] One-shot reloads, stops, clears run bit
// [R12] Software double-reads counter or stops first
// [R13] Flag set on underflow, write-one clears
// [R14] Source field selects four clock sources
// [R15] Divider is two to field power
// [R16] Run bit starts, stops, reads state
// [R17] Preset bit loads reload, reads busy
// [R18] Preset bit self-clears after load
// [R19] Reload register 16 bits, resets all ones
// [R20] Software keeps reload stable, one-shot nonzero
// [R21] Underflow on tick while counter zero
package rdt_pkg;
   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] RDT_CLK_OFS = 8'h00;
   localparam logic [7:0] RDT_MOD_OFS = 8'h04;
   localparam logic [7:0] RDT_CTL_OFS = 8'h08;
   localparam logic [7:0] RDT_RLD_OFS = 8'h0c;
   localparam logic [7:0] RDT_CNT_OFS = 8'h10;
   localparam logic [7:0] RDT_FLG_OFS = 8'h14;
   localparam logic [7:0] RDT_IEN_OFS = 8'h18;
   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int RDT_DEBUG_RUN_BIT = 8;
   localparam int RDT_DIV_LSB = 4;
   localparam int RDT_RUN_BIT = 8;
   localparam int RDT_PRESET_BIT = 1;
   localparam int RDT_MODULE_ENABLE_BIT = 0;
   localparam logic [15:0] RDT_RELOAD_RST = 16'hffff;
   localparam logic [1:0] RDT_SRC_INT = 2'h0;
   localparam logic [1:0] RDT_SRC_LOW = 2'h1;
   localparam logic [1:0] RDT_SRC_HIGH = 2'h2;
   localparam logic [1:0] RDT_SRC_EXT = 2'h3;
   localparam int RDT_SYNC_STAGES = 2;
   localparam int RDT_PRESCALE_W = 15;

   typedef struct packed {
      logic debugRun;
      logic [3:0] clockDividerSel;
      logic [1:0] clockSourceSel;
      logic repeatOneshotSel;
      logic moduleEnable;
      logic underflowIrqEn;
   } rdt_ctrl_s;
endpackage

// ===== tb/rdt_partner.sv
// Purpose: Far side of the timer: sources and underflow consumer
// Assumes: Source edges far slower than core_clk
// Notes: Counts underflow pulses and clock output rises
`timescale 1ns/100ps
module rdt_partner (
   input wire logic core_clk,
   input wire logic underflowPulse,
   input wire logic periphClock,
   output logic extEventIn,
   output logic internalOsc,
   output logic lowFreqOsc,
   output logic highFreqOsc,
   output logic extOscClock,
   output int ufCount,
   output int clkRises
);
   logic lastClk = 1'b0;
   initial begin
      extEventIn = 1'b0;
      internalOsc = 1'b0;
      lowFreqOsc = 1'b0;
      highFreqOsc = 1'b0;
      extOscClock = 1'b0;
      ufCount = 0;
      clkRises = 0;
   end
   // Source 0 event, 1 internal, 2 low, 3 high, 4 external oscillator
   // Four cycles per level, so the synchroniser sees every edge
   task automatic edges(input int src, input int n);
      repeat (n) begin
         @(posedge core_clk);
         case (src)
            1: internalOsc <= 1'b1;
            2: lowFreqOsc <= 1'b1;
            3: highFreqOsc <= 1'b1;
            4: extOscClock <= 1'b1;
            default: extEventIn <= 1'b1;
         endcase
         repeat (4) @(posedge core_clk);
         internalOsc <= 1'b0;
         lowFreqOsc <= 1'b0;
         highFreqOsc <= 1'b0;
         extOscClock <= 1'b0;
         extEventIn <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
   endtask
   always @(posedge core_clk) begin
      if (underflowPulse === 1'b1) ufCount <= ufCount + 1;
      lastClk <= periphClock;
      if (periphClock === 1'b1 && lastClk === 1'b0) clkRises <= clkRises + 1;
   end
endmodule

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the down timer channel
// Assumes: Offsets and fields as the package declares
// Notes: Event source drives counting in most cases
`timescale 1ns/100ps
module tb_top;
   import rdt_pkg::*;
   typedef struct packed {logic [7:0] a; logic [15:0] e;} rdt_row_s;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [15:0] regWrData = 16'h0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic sleepMode = 1'b0;
   logic sleepClockStopBit = 1'b0;
   logic debugMode = 1'b0;
   logic [15:0] regRdData;
   logic underflowPulse, periphClock, irqOut, extEventIn, internalOsc;
   logic lowFreqOsc, highFreqOsc, extOscClock;
   int ufCount, clkRises;
   int num_errors = 0;
   int total_checks = 0;
   // Last row is unmapped and must read zero
   rdt_row_s rows [8] = '{'{RDT_CLK_OFS, 16'h0000}, '{RDT_MOD_OFS, 16'h0000},
      '{RDT_CTL_OFS, 16'h0000}, '{RDT_RLD_OFS, RDT_RELOAD_RST}, '{RDT_CNT_OFS, 16'hffff},
      '{RDT_FLG_OFS, 16'h0000}, '{RDT_IEN_OFS, 16'h0000}, '{8'h1c, 16'h0000}};
   rdt_timer rdt_timer_i (.core_clk(core_clk), .rstn(rstn), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .internalOsc(internalOsc), .lowFreqOsc(lowFreqOsc),
      .highFreqOsc(highFreqOsc), .extOscClock(extOscClock), .extEventIn(extEventIn),
      .sleepMode(sleepMode), .sleepClockStopBit(sleepClockStopBit),
      .debugMode(debugMode), .underflowPulse(underflowPulse),
      .periphClock(periphClock), .irqOut(irqOut));
   rdt_partner rdt_partner_i (.core_clk(core_clk), .underflowPulse(underflowPulse),
      .periphClock(periphClock), .extEventIn(extEventIn), .internalOsc(internalOsc),
      .lowFreqOsc(lowFreqOsc), .highFreqOsc(highFreqOsc), .extOscClock(extOscClock),
      .ufCount(ufCount), .clkRises(clkRises));
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   // ************************************************************
   // Bus and compare tasks
   // ************************************************************
   task automatic end_of_test();
      if (num_errors == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
         num_errors++;
      end
   endtask
   task automatic chkCount(input string what, input int exp, input int got);
      total_checks++;
      if (got != exp) begin
         $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
         num_errors++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask
   // Read strobe right behind the write, to catch one-cycle status
   task automatic wrRd(input logic [7:0] a, input logic [15:0] d, input logic [7:0] ra,
      input logic [15:0] exp);
      @(posedge core_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWrite <= 1'b0;
      regRead <= 1'b1;
      regAddr <= ra;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1;
      chk($sformatf("reg %h", ra), exp, regRdData);
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1;
      chk($sformatf("reg %h", a), exp, regRdData);
   endtask
   initial begin
      #1ms;
      num_errors++;
      end_of_test();
   end
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      foreach (rows[i]) rd(rows[i].a, rows[i].e);
      wr(RDT_CLK_OFS, 16'h0003);
      wr(RDT_CTL_OFS, 16'h0100);
      rd(RDT_CTL_OFS, 16'h0000);
      wr(RDT_CTL_OFS, 16'h0001);
      wr(RDT_MOD_OFS, 16'h0000);
      wr(RDT_RLD_OFS, 16'h0002);
      wr(RDT_FLG_OFS, 16'h0001);
      wr(RDT_IEN_OFS, 16'h0001);
      wrRd(RDT_CTL_OFS, 16'h0103, RDT_CTL_OFS, 16'h0103);
      rd(RDT_CTL_OFS, 16'h0101);
      rd(RDT_CNT_OFS, 16'h0002);
      rdt_partner_i.edges(1'b0, 1);
      rd(RDT_CNT_OFS, 16'h0001);
      rdt_partner_i.edges(4, 1);
      rd(RDT_CNT_OFS, 16'h0001);
      rdt_partner_i.edges(1'b0, 2);
      rd(RDT_CNT_OFS, 16'h0002);
      chkCount("underflows", 1, ufCount);
      rd(RDT_FLG_OFS, 16'h0001);
      chk("irqOut", 16'h0001, {15'h0, irqOut});
      rdt_partner_i.edges(1'b0, 3);
      chkCount("underflows", 2, ufCount);
      chkCount("clock rises", 1, clkRises);
      rd(RDT_CTL_OFS, 16'h0101);
      wr(RDT_FLG_OFS, 16'h0000);
      rd(RDT_FLG_OFS, 16'h0001);
      wr(RDT_FLG_OFS, 16'h0001);
      rd(RDT_FLG_OFS, 16'h0000);
      chk("irqOut", 16'h0000, {15'h0, irqOut});
      sleepMode <= 1'b1;
      sleepClockStopBit <= 1'b1;
      rdt_partner_i.edges(1'b0, 1);
      rd(RDT_CNT_OFS, 16'h0002);
      sleepMode <= 1'b0;
      rdt_partner_i.edges(1'b0, 1);
      rd(RDT_CNT_OFS, 16'h0001);
      debugMode <= 1'b1;
      rdt_partner_i.edges(1'b0, 1);
      rd(RDT_CNT_OFS, 16'h0001);
      wr(RDT_CLK_OFS, 16'h0103);
      rdt_partner_i.edges(1'b0, 1);
      rd(RDT_CNT_OFS, 16'h0000);
      debugMode <= 1'b0;
      wr(RDT_CTL_OFS, 16'h0001);
      rd(RDT_CTL_OFS, 16'h0001);
      wr(RDT_MOD_OFS, 16'h0001);
      wr(RDT_RLD_OFS, 16'h0001);
      wr(RDT_CTL_OFS, 16'h0103);
      rdt_partner_i.edges(1'b0, 2);
      rd(RDT_CTL_OFS, 16'h0001);
      rdt_partner_i.edges(1'b0, 1);
      rd(RDT_CNT_OFS, 16'h0001);
      chkCount("underflows", 3, ufCount);
      chkCount("clock rises", 1, clkRises);
      // Divide by two: four oscillator edges give two ticks
      wr(RDT_CLK_OFS, 16'h0010);
      wr(RDT_MOD_OFS, 16'h0000);
      wr(RDT_RLD_OFS, 16'h0010);
      wr(RDT_CTL_OFS, 16'h0103);
      rdt_partner_i.edges(1'b1, 4);
      rd(RDT_CNT_OFS, 16'h000e);
      rd(RDT_CNT_OFS, 16'h000e);
      wr(RDT_CLK_OFS, 16'h0001);
      rdt_partner_i.edges(3, 1);
      rd(RDT_CNT_OFS, 16'h000e);
      rdt_partner_i.edges(2, 1);
      rd(RDT_CNT_OFS, 16'h000d);
      wr(RDT_CLK_OFS, 16'h0002);
      rdt_partner_i.edges(3, 1);
      rd(RDT_CNT_OFS, 16'h000c);
      wr(RDT_CLK_OFS, 16'h00f3);
      rdt_partner_i.edges(0, 1);
      rd(RDT_CNT_OFS, 16'h000b);
      end_of_test();
   end
endmodule
